// >>> adcc_ctrl.sv
// serial slave, command decode, conversion and reference control
`timescale 1ns/1ps
// Summary of operation
// - mode bit 0 selects differential pairs, 1 selects single-ended.
// - reference and converter power bits decode the four power modes.
// - differential pairs inputs 2k,2k+1; top channel bit picks polarity.
// - single-ended routes input {low two bits, top bit} against common.
// - four-input variant accepts only codes addressing inputs 0 to 3.
// - write addressing powers converter; conversion requested at low bit, starts once powered.
// - acknowledge only a matching address byte.
// - read-addressed device transmits result bytes to the master.
// - result goes out as two bytes, upper part first.
// - first byte is four zeros then bits 11..8; second bits 7..0.
// - converter powers when its bit arrives; needs 1.4 us.
// - reference is off after power-up.
// - reference turns on at stop or restart after bit set.
// - further commands with reference bit set just keep it on.
// - any command with reference bit clear turns reference off.
// - address is prefix, two strapped select bits, direction bit.
// - matching address and command bytes are acknowledged low on ninth clock.
module adcc_ctrl #(
  parameter bit P_EIGHT_INPUTS = 1'b1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // serial bus pins and address straps
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_address_select_high,
  input wire logic i_address_select_low,
  // converter core
  output logic o_conv_start,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_result,
  output logic o_conv_power,
  output logic o_ref_power,
  // input multiplexer
  output logic o_input_mode_select,
  output logic [2:0] o_mux_pos_sel,
  output logic [2:0] o_mux_neg_sel,
  output logic o_mux_neg_common,
  // status
  output logic o_chan_unsupported,
  output logic o_result_valid
);
  import adcc_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic [3:0] pin_level;
  logic scl_f;
  logic sda_f;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [1:0] addr_sel_reg;
  logic [2:0] strap_cnt_reg;

  adcc_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_scl, i_sda, i_address_select_high, i_address_select_low}),
    .o_level(pin_level)
  );
  assign scl_f = pin_level[3];
  assign sda_f = pin_level[2];

  // previous levels for edge finding
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
    end
  end

  // bus conditions: data edge while clock stays high
  assign scl_rise = scl_f && !scl_prev_reg;
  assign scl_fall = !scl_f && scl_prev_reg;
  assign start_det = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
  assign stop_det = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      strap_cnt_reg <= 3'h0;
      addr_sel_reg <= 2'h0;
    end
    else if (strap_cnt_reg != ADCC_STRAP_WAIT)
    begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      addr_sel_reg <= pin_level[1:0];
    end
  end

  // ---------------------------------------------------------------
  // serial slave state machine
  // ---------------------------------------------------------------
  adcc_state_t st_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic full_reg;
  logic rw_reg;
  logic drive_low_reg;
  logic byte_sel_reg;
  logic addr_match;
  logic tx_load;
  logic [7:0] next_byte;
  logic [7:0] cmd_byte;
  logic cmd_done;
  logic chan_rx;
  logic conv_rx;
  logic [11:0] result_reg;

  assign addr_match = rx_shift_reg[7:1] == {ADCC_ADDR_PREFIX, addr_sel_reg};
  assign cmd_byte = {rx_shift_reg[6:0], sda_f};
  assign chan_rx = scl_rise && st_reg == ST_CMD && bit_cnt_reg == ADCC_CNT_CHAN;
  assign conv_rx = scl_rise && st_reg == ST_CMD && bit_cnt_reg == ADCC_CNT_CONV;
  assign cmd_done = scl_rise && st_reg == ST_CMD && bit_cnt_reg == ADCC_CNT_LAST;
  // transmit after read address; byte order
  assign tx_load = scl_fall && ((st_reg == ST_ADDR_ACK && rw_reg) ||
                                (st_reg == ST_TX_ACK && full_reg));
  assign next_byte = byte_sel_reg ? result_reg[7:0]
                                  : {ADCC_BYTE0_PAD, result_reg[11:8]};

  // byte framing, acknowledge and transmit
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      full_reg <= 1'b0;
      rw_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      byte_sel_reg <= 1'b0;
    end
    else if (start_det)
    begin
      st_reg <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
      full_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      byte_sel_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      st_reg <= ST_IDLE;
      drive_low_reg <= 1'b0;
    end
    else if (tx_load)
    begin
      st_reg <= ST_TX;
      bit_cnt_reg <= 3'h0;
      full_reg <= 1'b0;
      tx_shift_reg <= {next_byte[6:0], 1'b0};
      drive_low_reg <= !next_byte[7];
      byte_sel_reg <= !byte_sel_reg;
    end
    else
    begin
      unique case (st_reg)
        ST_IDLE: ;
        ST_ADDR, ST_CMD:
        begin
          if (scl_rise)
          begin
            rx_shift_reg <= cmd_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            full_reg <= bit_cnt_reg == ADCC_CNT_LAST;
          end
          else if (scl_fall && full_reg)
          begin
            full_reg <= 1'b0;
            if (st_reg == ST_CMD || addr_match)
            begin
              // hold data low through ninth clock
              drive_low_reg <= 1'b1;
              st_reg <= (st_reg == ST_CMD) ? ST_CMD_ACK : ST_ADDR_ACK;
              if (st_reg == ST_ADDR)
                rw_reg <= rx_shift_reg[0];
            end
            else
              st_reg <= ST_IDLE;
          end
        end
        ST_ADDR_ACK, ST_CMD_ACK:
        begin
          if (scl_fall)
          begin
            drive_low_reg <= 1'b0;
            st_reg <= ST_CMD;
            bit_cnt_reg <= 3'h0;
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            full_reg <= bit_cnt_reg == ADCC_CNT_LAST;
          end
          else if (scl_fall && full_reg)
          begin
            drive_low_reg <= 1'b0;
            full_reg <= 1'b0;
            st_reg <= ST_TX_ACK;
          end
          else if (scl_fall)
          begin
            drive_low_reg <= !tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          end
        end
        ST_TX_ACK:
        begin
          // master acknowledge low means another byte
          if (scl_rise)
            full_reg <= !sda_f;
          else if (scl_fall)
            st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_sda = 1'b0;
  assign o_sda_oe_n = !drive_low_reg;

  // ---------------------------------------------------------------
  // command fields and multiplexer
  // ---------------------------------------------------------------
  logic chan_ok;
  logic pd0_reg;

  // four-input variant has no inputs 4 to 7
  // middle channel bit sits in the shift register's lowest bit here
  assign chan_ok = P_EIGHT_INPUTS || !rx_shift_reg[0];

  // field positions within the command byte
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_input_mode_select <= 1'b0;
      o_mux_pos_sel <= 3'h0;
      o_mux_neg_sel <= 3'h1;
      o_mux_neg_common <= 1'b0;
      o_chan_unsupported <= 1'b0;
      pd0_reg <= 1'b0;
    end
    else
    begin
      if (chan_rx)
      begin
        o_input_mode_select <= cmd_byte[ADCC_BIT_MODE - ADCC_BIT_CH_LO];
        o_mux_neg_common <= cmd_byte[ADCC_BIT_MODE - ADCC_BIT_CH_LO];
        o_mux_pos_sel <= {rx_shift_reg[0], sda_f, rx_shift_reg[1]};
        o_mux_neg_sel <= {rx_shift_reg[0], sda_f, !rx_shift_reg[1]};
        o_chan_unsupported <= !chan_ok;
      end
      // converter power bit acts as soon as it arrives
      if (conv_rx)
        pd0_reg <= sda_f;
    end
  end

  // ---------------------------------------------------------------
  // reference control
  // ---------------------------------------------------------------
  logic ref_pend_reg;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_ref_power <= 1'b0;
      ref_pend_reg <= 1'b0;
    end
    else if (cmd_done && !cmd_byte[ADCC_BIT_REF])
    begin
      o_ref_power <= 1'b0;
      ref_pend_reg <= 1'b0;
    end
    else if (cmd_done && !o_ref_power)
      ref_pend_reg <= 1'b1;
    else if ((start_det || stop_det) && ref_pend_reg)
    begin
      // turn-on at stop or repeated start
      o_ref_power <= 1'b1;
      ref_pend_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // conversion control and converter power
  // ---------------------------------------------------------------
  logic write_sess_reg;
  logic conv_req_reg;
  logic busy_reg;
  logic [7:0] pwr_cnt_reg;
  logic powered;

  // converter bit plus activity decide power
  assign o_conv_power = write_sess_reg || pd0_reg || busy_reg || conv_req_reg;
  assign powered = pwr_cnt_reg == ADCC_PWRUP_CNT;

  // write addressing opens a powered session
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || start_det || stop_det)
      write_sess_reg <= 1'b0;
    else if (st_reg == ST_ADDR_ACK && !rw_reg)
      write_sess_reg <= 1'b1;
  end

  // power-up time before a conversion may start
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || !o_conv_power)
      pwr_cnt_reg <= 8'h00;
    else if (!powered)
      pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
  end

  // request at channel low bit, start once powered; a new request wins over the clear
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      conv_req_reg <= 1'b0;
      busy_reg <= 1'b0;
      o_conv_start <= 1'b0;
      result_reg <= ADCC_RESULT_RST;
      o_result_valid <= 1'b0;
    end
    else
    begin
      o_conv_start <= 1'b0;
      if (conv_req_reg && powered && !busy_reg)
      begin
        o_conv_start <= 1'b1;
        busy_reg <= 1'b1;
        conv_req_reg <= 1'b0;
      end
      else if (busy_reg && i_conv_done)
      begin
        busy_reg <= 1'b0;
        result_reg <= i_conv_result;
        o_result_valid <= 1'b1;
      end
      if (chan_rx && chan_ok)
        conv_req_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_ref_reset_off: assert property (
    $rose(i_rst_n) |-> !o_ref_power)
    else $error("reference on after reset");
  a_ref_turn_on: assert property (
    $rose(o_ref_power) |-> $past(ref_pend_reg) &&
      ($past(start_det) || $past(stop_det)))
    else $error("reference turned on without stop or restart");
  a_ref_kept_on: assert property (
    o_ref_power && cmd_done && cmd_byte[ADCC_BIT_REF] |=>
      o_ref_power && !ref_pend_reg)
    else $error("reference turn-on restarted");
  a_ref_cmd_off: assert property (
    cmd_done && !cmd_byte[ADCC_BIT_REF] |=> !o_ref_power)
    else $error("reference stayed on after clear bit");
  a_mux_route: assert property (
    $past(chan_rx) |-> o_mux_pos_sel[0] != o_mux_neg_sel[0] &&
      o_mux_pos_sel[2:1] == o_mux_neg_sel[2:1])
    else $error("differential pair routing wrong");
  a_single_common: assert property (
    o_input_mode_select |-> o_mux_neg_common)
    else $error("single-ended not against common");
  a_addr_ack_match: assert property (
    scl_fall && st_reg == ST_ADDR && full_reg |=>
      drive_low_reg == $past(addr_match))
    else $error("address acknowledge mismatch");
  a_byte0_format: assert property (
    tx_load && !byte_sel_reg |=> drive_low_reg &&
      tx_shift_reg == {3'h0, $past(result_reg[11:8]), 1'b0})
    else $error("first result byte badly formed");
  a_start_power: assert property (
    o_conv_start |-> o_conv_power && $past(powered, 1))
    else $error("conversion started unpowered");
  a_busy_power: assert property (
    busy_reg |-> o_conv_power)
    else $error("converter off during conversion");
  a_chan_valid: assert property (
    chan_rx && !chan_ok |=> !conv_req_reg || $past(conv_req_reg))
    else $error("unsupported channel started");
endmodule // adcc_ctrl

// >>> adcc_pkg.sv
// shared constants and types for the converter command and readout control
package adcc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int ADCC_CLK_PERIOD_NS = 8;
  localparam int ADCC_PWRUP_NS = 1400;
  localparam int ADCC_PWRUP_CYC =
    (ADCC_PWRUP_NS + ADCC_CLK_PERIOD_NS - 1) / ADCC_CLK_PERIOD_NS;
  localparam logic [7:0] ADCC_PWRUP_CNT = 8'(ADCC_PWRUP_CYC);
  // straps are taken until the three-stage filter has settled
  localparam logic [2:0] ADCC_STRAP_WAIT = 3'h6;

  // ---------------------------------------------------------------
  // command byte field positions
  // ---------------------------------------------------------------
  localparam int ADCC_BIT_MODE = 7;
  localparam int ADCC_BIT_CH_HI = 6;
  localparam int ADCC_BIT_CH_LO = 4;
  localparam int ADCC_BIT_REF = 3;
  localparam int ADCC_BIT_CONV = 2;

  // bit counter values at which fields are complete
  localparam logic [2:0] ADCC_CNT_CHAN = 3'h3;
  localparam logic [2:0] ADCC_CNT_CONV = 3'h5;
  localparam logic [2:0] ADCC_CNT_LAST = 3'h7;

  // ---------------------------------------------------------------
  // address and reset values
  // ---------------------------------------------------------------
  // device type prefix: value is arbitrary
  localparam logic [4:0] ADCC_ADDR_PREFIX = 5'h0d;
  localparam logic [11:0] ADCC_RESULT_RST = 12'h000;
  localparam logic [3:0] ADCC_BYTE0_PAD = 4'h0;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_TX, ST_TX_ACK
  } adcc_state_t;

endpackage

// >>> adcc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module adcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // asynchronous input and filtered level
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // shift chain; first stage feeds only the second
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree, per bit
  for (genvar b = 0; b < W; b++)
  begin : g_filt
    always_ff @(posedge i_core_clk)
    begin
      if (!i_rst_n)
        o_level[b] <= RST_VAL[b];
      else if (s2_reg[b] == s3_reg[b])
        o_level[b] <= s3_reg[b];
    end
  end
endmodule // adcc_sync

// >>> adcc_i2c_master.sv
// two-wire bus master model that drives clock and data for the bench
`timescale 1ns/1ps
module adcc_i2c_master (
  // bus pins
  output logic o_scl,
  output logic o_sda_oe_n,
  input wire logic i_sda
);
  // ---------------------------------------------------------------
  // bit timing: low phase outlasts the slave's reply latency
  // ---------------------------------------------------------------
  // 64 ns period; the slave answers 36 ns after a falling clock
  localparam int TL = 48;
  localparam int TH = 16;

  // bus idles released and high
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  // ---------------------------------------------------------------
  // bus conditions
  // ---------------------------------------------------------------
  // start, or repeated start when the clock is low
  task automatic bus_start();
    if (!o_scl)
    begin
      #8 o_sda_oe_n = 1'b1;
      #(TL - 8) o_scl = 1'b1;
    end
    #TH o_sda_oe_n = 1'b0;
    #TH o_scl = 1'b0;
  endtask

  // data rises while the clock is high
  task automatic bus_stop();
    #8 o_sda_oe_n = 1'b0;
    #(TL - 8) o_scl = 1'b1;
    #TH o_sda_oe_n = 1'b1;
    #TL;
  endtask

  // ---------------------------------------------------------------
  // bit and byte transfers
  // ---------------------------------------------------------------
  // data set early in the low phase, line read at the end of high
  task automatic bus_bit(input logic b, output logic r);
    #8 o_sda_oe_n = b;
    #(TL - 8) o_scl = 1'b1;
    #(TH - 4) r = i_sda;
    #4 o_scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int k = 7; k >= 0; k--)
      bus_bit(b[k], r);
    bus_bit(1'b1, ack_n);
  endtask

  // read bytes, high ack ends the read
  task automatic get_byte(input logic ack_n, output logic [7:0] b);
    logic r;
    for (int k = 7; k >= 0; k--)
    begin
      bus_bit(1'b1, r);
      b[k] = r;
    end
    bus_bit(ack_n, r);
  endtask
endmodule // adcc_i2c_master

// >>> tb.sv
// self-checking bench for the command and readout control
`timescale 1ns/1ps
module tb;
  import adcc_pkg::*;
  // ---------------------------------------------------------------
  // signals and bench state
  // ---------------------------------------------------------------
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic a_hi = 1'b0;
  logic a_lo = 1'b0;
  logic conv_done = 1'b0;
  logic [11:0] conv_res = 12'h000;
  wire logic scl;
  wire logic m_oe_n;
  wire logic sda_line;
  logic sda_out, sda_oe_n, conv_start, conv_pwr, ref_pwr, mode, neg_com;
  logic unsup, res_valid;
  logic [2:0] pos_sel, neg_sel;
  logic [31:0] lf = 32'he2826882;
  int err_count = 0;
  int checks_done = 0;
  int pw_cnt = 0;
  int busy = 0;
  int n;
  int q[$];

  always #4 i_core_clk = ~i_core_clk;

  // open-drain line with pull-up
  assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & m_oe_n;

  adcc_ctrl dut (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_scl(scl),
    .i_sda(sda_line),
    .o_sda(sda_out),
    .o_sda_oe_n(sda_oe_n),
    .i_address_select_high(a_hi),
    .i_address_select_low(a_lo),
    .o_conv_start(conv_start),
    .i_conv_done(conv_done),
    .i_conv_result(conv_res),
    .o_conv_power(conv_pwr),
    .o_ref_power(ref_pwr),
    .o_input_mode_select(mode),
    .o_mux_pos_sel(pos_sel),
    .o_mux_neg_sel(neg_sel),
    .o_mux_neg_common(neg_com),
    .o_chan_unsupported(unsup),
    .o_result_valid(res_valid)
  );

  adcc_i2c_master m (
    .o_scl(scl),
    .o_sda_oe_n(m_oe_n),
    .i_sda(sda_line)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lf_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out();
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a bounded wait that ran out ends the run
  task automatic tmo(input int k, input int lim);
    if (k >= lim)
    begin
      err_count++;
      close_out();
    end
  endtask

  // ---------------------------------------------------------------
  // converter core model: fixed busy time, random results queued
  // ---------------------------------------------------------------
  always @(negedge i_core_clk)
  begin
    conv_done <= 1'b0;
    pw_cnt <= conv_pwr ? pw_cnt + 1 : 0;
    if (conv_start)
    begin
      chk(12'(pw_cnt >= ADCC_PWRUP_CYC - 1), 12'h001);
      busy <= 20;
    end
    else if (busy == 1)
    begin
      lf = lf_next(lf);
      conv_res <= lf[11:0];
      conv_done <= 1'b1;
      q.push_back(int'(lf[11:0]));
      busy <= 0;
    end
    else if (busy > 1)
      busy <= busy - 1;
  end

  // watchdog on the whole run
  initial
  begin
    #400000;
    err_count++;
    close_out();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic ack_n;
    logic ref_old;
    logic [7:0] cmd, b0, b1;
    logic [6:0] addr;
    int rv;
    lf = lf_next(lf);
    a_hi = lf[5];
    a_lo = lf[9];
    addr = {ADCC_ADDR_PREFIX, a_hi, a_lo};
    repeat (12) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_core_clk);
    chk(12'(ref_pwr), 12'h000);
    chk(12'({conv_pwr, sda_oe_n, res_valid}), 12'h002);
    // foreign prefix, then foreign strap bits
    for (int w = 0; w < 2; w++)
    begin
      m.bus_start();
      m.put_byte({addr ^ (w == 0 ? 7'h10 : 7'h01), 1'b0}, ack_n);
      chk(12'(ack_n), 12'h001);
      m.bus_stop();
    end
    for (int i = 0; i < 16; i++)
    begin
      lf = lf_next(lf);
      // reference bit turns on at restart, stop, and keeps
      cmd = {i[3:0], i[2] ^ i[0], lf[2:0]};
      ref_old = ref_pwr;
      m.bus_start();
      m.put_byte({addr, 1'b0}, ack_n);
      chk(12'(ack_n), 12'h000);
      m.put_byte(cmd, ack_n);
      chk(12'(ack_n), 12'h000);
      chk(12'(mode), 12'(cmd[7]));
      chk(12'({pos_sel, neg_com}), 12'({cmd[5:4], cmd[6], cmd[7]}));
      if (!cmd[7])
        chk(12'(neg_sel), 12'({cmd[5:4], ~cmd[6]}));
      chk(12'(unsup), 12'h000);
      chk(12'(ref_pwr), 12'(ref_old & cmd[3]));
      if (i[0])
      begin
        m.bus_start();
        // quiet time after a repeated start
        repeat (463) @(negedge i_core_clk);
      end
      else
      begin
        m.bus_stop();
        m.bus_start();
      end
      chk(12'(ref_pwr), 12'(cmd[3]));
      // read only after the result is queued; model needs no settling
      for (n = 0; n < 2000 && q.size() == 0; n++)
        @(negedge i_core_clk);
      tmo(n, 2000);
      m.put_byte({addr, 1'b1}, ack_n);
      chk(12'(ack_n), 12'h000);
      m.get_byte(1'b0, b0);
      m.get_byte(1'b1, b1);
      m.bus_stop();
      rv = q.pop_front();
      chk({b0[3:0], b1}, 12'(rv));
      chk(12'(b0[7:4]), 12'h000);
      chk(12'({conv_pwr, res_valid}), 12'({cmd[2], 1'b1}));
    end
    close_out();
  end
endmodule // tb
